// ---- inc/sfb_pkg.sv ----
// sfb_pkg: constants, carriers and states of the serial boot/master block
// assumes a single 125 MHz clock domain shared by all units
// What this block does
// R1: after reset use 24-bit addresses, four 16 MB windows, one per select
// R2: wide address bit maps whole 256 MB onto select 0, sends 32 bits
// R3: a read in one select's window runs a flash read on that select
// R4: byte, halfword, word reads, single or burst; no write path exists
// R5: manual pin bit hands pin enables and levels to control bits
// R6: boot reader never asserts more than one select at once
// R7: after serving word n, speculatively fetch word n+1
// R8: quick read bit selects fast command; gap field sets select-high time
// R9: software keeps serial clock at or under 25 MHz and flash limit
// R10: defaults give about 8.3 MHz, normal reads, largest select gap
// R11: divider written last or together; accepted during boot reads
// R12: sample data input just before driving each falling clock edge of the data word
// R13: software hands pins to the master by writing owner value 2
// R14: SPI framing by default, SSP when format is 1 and SSP enable set
// R15: frame length 4 to 16 bits, one frame per FIFO entry
// R16: tx/rx mode pairs frames, tx mode drops rx; run while tx data left
// R17: receive mode: one dummy frame starts a read of the frame count
// R18: SPI framing holds selects for the transfer, ends on tx FIFO empty, or in receive mode when the frame count runs out
// R19: software waits for tx empty and not busy before a new transfer
// R20: up to five active-low selects chosen by the slave select mask
// R21: data port write pushes tx, read pops rx; four FIFO flags reported
// R22: rx sample delayed by programmed cycles, over 25 means none; locked
// R23: software keeps clock phase and polarity zero under SSP framing
// R24: pin mux follows owner field, boot reader owns after reset
// R25: disable-only registers ignore writes while master is enabled
package sfb_pkg;
  localparam logic [7:0]  CMD_READ   = 8'h03;
  localparam logic [7:0]  CMD_QUICK  = 8'h0B;
  localparam logic [7:0]  DIV_RST    = 8'h0F; // 125 MHz / 15
  localparam logic [3:0]  GAP_RST    = 4'hF;
  localparam logic [1:0]  OWN_MST    = 2'h2;
  localparam logic [7:0]  DLY_MAX    = 8'h19;
  localparam logic [5:0]  HDR_BASE   = 6'h20;
  localparam logic [5:0]  HDR_EXT    = 6'h08;
  localparam logic [5:0]  WORD_BITS  = 6'h20;
  localparam logic [3:0]  FIFO_FULL  = 4'h8;
  localparam logic [3:0]  LEN_MIN    = 4'h3;

  typedef enum logic [1:0] {
    TM_TXRX = 2'b00,
    TM_TX   = 2'b01,
    TM_RX   = 2'b10
  } sfb_tmode_e;

  typedef enum logic [2:0] {
    B_IDLE = 3'b000,
    B_HDR  = 3'b001,
    B_DATA = 3'b010,
    B_HOLD = 3'b011,
    B_GAP  = 3'b100
  } sfb_bstate_e;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_SYNC = 2'b01,
    M_BIT  = 2'b10,
    M_END  = 2'b11
  } sfb_mstate_e;

  typedef struct packed {
    logic [7:0] clkDiv;
    logic [3:0] selGap;
    logic       quick;
    logic       wide;
  } sfb_boot_cfg_s;

  typedef struct packed {
    logic       en;
    logic       clkOe;
    logic       clk;
    logic       doOe;
    logic       dOut;
    logic [3:0] csOe;
    logic [3:0] csLvl;
  } sfb_manual_s;

  typedef struct packed {
    logic [3:0]  frameLen;
    sfb_tmode_e  mode;
    logic [1:0]  fmtSel;
    logic        sspEn;
    logic [15:0] baud;
    logic [15:0] rxCount;
    logic [4:0]  selMask;
  } sfb_mst_cfg_s;

  localparam sfb_boot_cfg_s BOOT_CFG_RST = '{DIV_RST, GAP_RST, 1'b0, 1'b0};
  localparam sfb_mst_cfg_s  MST_CFG_RST  =
    '{4'h7, TM_TXRX, 2'h0, 1'b0, 16'h0006, 16'h0000, 5'h00};
endpackage : sfb_pkg

// ---- logic/sfb_serial_top.sv ----
// sfb_serial_top: boot reader, FIFO master and shared serial pin mux
// assumes a bus that holds bootReq until bootAck, and async data input
`timescale 1ns/1ps
module sfb_serial_top
  import sfb_pkg::*;
(
  input  logic          mclk,
  input  logic          reset_n,
  input  logic          clkEn,
  input  logic [1:0]    ifOwner,
  input  logic          bootCfgWr,
  input  sfb_boot_cfg_s bootCfgIn,
  input  sfb_manual_s   manualCtl,
  input  logic          bootReq,
  input  logic [27:0]   bootAddr,
  output logic          bootAck,
  output logic [31:0]   bootData,
  input  logic          mstEnable,
  input  logic          mstCfgWr,
  input  sfb_mst_cfg_s  mstCfgIn,
  input  logic          dlyWr,
  input  logic [7:0]    dlyIn,
  input  logic          txPush,
  input  logic [15:0]   txData,
  input  logic          rxPop,
  output logic [15:0]   rxData,
  output logic          txEmpty,
  output logic          txNotFull,
  output logic          rxFull,
  output logic          rxNotEmpty,
  output logic          mstBusy,
  input  logic          serialDataIn,
  output logic          manualDataInLevel,
  output logic          sclkOut,
  output logic          sclkOe,
  output logic          sdoOut,
  output logic          sdoOe,
  output logic [4:0]    selN,
  output logic [4:0]    selOe
);
  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  logic din1, din2;
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      din1 <= 1'b0;
      din2 <= 1'b0;
    end
    else if (clkEn)
    begin
      din1 <= serialDataIn;
      din2 <= din1;
    end

  // ----------------------------------------------------------------
  // boot reader
  // ----------------------------------------------------------------
  sfb_boot_cfg_s bCfg, bPend;
  sfb_bstate_e   bState;
  logic          bPendV, bApply, bootOwn, hit, ackNow;
  logic [7:0]    bDiv;
  logic          bMid, bEnd, bCsAct, sclkB, bufV;
  logic [47:0]   bSh, hdr;
  logic [5:0]    bLeft, hdrLen;
  logic [1:0]    bCs, reqCs;
  logic [31:0]   bRx, bufData;
  logic [25:0]   bufTag, nextTag;
  logic [3:0]    gapCnt, bSelN;
  logic [7:0]    cmd;

  // one clock period is clkDiv cycles; high phase is the second half
  assign bMid = bDiv == ({1'b0, bCfg.clkDiv[7:1]} - 8'h01);
  assign bEnd = bDiv == (bCfg.clkDiv - 8'h01);
  assign bootOwn = (ifOwner != OWN_MST) && !manualCtl.en;
  assign hit = bufV && (bufTag == bootAddr[27:2]);
  assign ackNow = bootReq && hit && !bootAck; // [R4]
  assign bApply = bPendV && (bState == B_IDLE) && !bootCfgWr;
  assign reqCs = bCfg.wide ? 2'h0 : bootAddr[25:24]; // [R1] [R2]
  assign cmd = bCfg.quick ? CMD_QUICK : CMD_READ; // [R8]
  assign hdrLen = HDR_BASE + (bCfg.wide ? HDR_EXT : 6'h00)
                + (bCfg.quick ? HDR_EXT : 6'h00); // [R2] [R8]
  assign hdr = bCfg.wide ? {cmd, 4'h0, bootAddr[27:2], 2'b00, 8'h00}
                         : {cmd, bootAddr[23:2], 2'b00, 16'h0000};
  assign bSelN = bCsAct ? ~(4'h1 << bCs) : 4'hF; // [R6] [R3]

  // new config waits for an idle bus so the divider never jumps mid-word;
  // a write in the apply cycle wins and is applied next time round
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      bCfg   <= BOOT_CFG_RST; // [R10] [R1]
      bPend  <= BOOT_CFG_RST;
      bPendV <= 1'b0;
    end
    else if (clkEn)
    begin
      if (bootCfgWr)
      begin
        bPend  <= bootCfgIn; // [R11]
        bPendV <= 1'b1;
      end
      else if (bApply)
      begin
        bCfg   <= bPend;
        bPendV <= 1'b0;
      end
    end

  // read sequencer: header, data word, then hold with clock stopped
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      bState  <= B_IDLE;
      bDiv    <= 8'h00;
      bSh     <= '0;
      bLeft   <= 6'h00;
      bCs     <= 2'h0;
      bCsAct  <= 1'b0;
      sclkB   <= 1'b0;
      bRx     <= '0;
      bufData <= '0;
      bufTag  <= '0;
      bufV    <= 1'b0;
      nextTag <= '0;
      gapCnt  <= 4'h0;
    end
    else if (clkEn)
    begin
      bDiv <= bEnd ? 8'h00 : bDiv + 8'h01;
      unique case (bState)
        B_IDLE:
          if (bApply)
            bufV <= 1'b0;
          else if (bootReq && !hit && bootOwn)
          begin
            bState  <= B_HDR; // [R3]
            bDiv    <= 8'h00;
            bCsAct  <= 1'b1;
            bCs     <= reqCs;
            bSh     <= hdr;
            bLeft   <= hdrLen;
            nextTag <= bootAddr[27:2];
            bufV    <= 1'b0;
          end
        B_HDR:
          if (bMid)
            sclkB <= 1'b1;
          else if (bEnd)
          begin
            sclkB <= 1'b0;
            bSh   <= {bSh[46:0], 1'b0};
            bLeft <= bLeft - 6'h01;
            if (bLeft == 6'h01)
            begin
              bState <= B_DATA;
              bLeft  <= WORD_BITS;
            end
          end
        B_DATA:
          if (bMid)
            sclkB <= 1'b1;
          else if (bEnd)
          begin
            sclkB <= 1'b0;
            bRx   <= {bRx[30:0], din2}; // [R12]
            bLeft <= bLeft - 6'h01;
            if (bLeft == 6'h01)
            begin
              bufData <= {bRx[30:0], din2};
              bufTag  <= nextTag;
              bufV    <= 1'b1;
              nextTag <= nextTag + 26'h1;
              bState  <= B_HOLD;
            end
          end
        B_HOLD:
          if (ackNow && (bufTag == nextTag - 26'h1))
          begin
            bState <= B_DATA; // [R7]
            bLeft  <= WORD_BITS;
            bDiv   <= 8'h00;
          end
          else if ((bootReq && !hit) || bPendV || !bootOwn)
          begin
            bState <= B_GAP;
            bCsAct <= 1'b0;
            gapCnt <= bCfg.selGap; // [R8]
            bDiv   <= 8'h00;
          end
        B_GAP:
          if (bEnd)
          begin
            if (gapCnt == 4'h0)
              bState <= B_IDLE;
            else
              gapCnt <= gapCnt - 4'h1;
          end
        default:
          bState <= B_IDLE;
      endcase
    end

  // answer from the prefetch buffer, whole aligned word for every size
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      bootAck  <= 1'b0;
      bootData <= '0;
    end
    else if (clkEn)
    begin
      bootAck <= ackNow; // [R4]
      if (ackNow)
        bootData <= bufData;
    end

  // ----------------------------------------------------------------
  // FIFO master: config, FIFOs, frame engine, sampler
  // ----------------------------------------------------------------
  sfb_mst_cfg_s mCfg;
  sfb_mstate_e  mState;
  logic [7:0]   mDly, mDlyCnt, dlyEff;
  logic [15:0]  txMem [0:7];
  logic [15:0]  rxMem [0:7];
  logic [2:0]   txWr, txRd, rxWr, rxRd;
  logic [3:0]   txCnt, rxCnt, flen, mBits;
  logic         txIn, rxOut, mTxPop, mRxPush, mStart, mDone, mMore;
  logic         ssp, mMid, mEnd, mArm, sclkM, mSelAct, mSelOn;
  logic [15:0]  mDiv, mSh, rxSh, rxWord, mFrames, txHead;

  function automatic logic [3:0] cntNext(logic [3:0] c, logic up,
                                         logic dn);
    cntNext = c + {3'h0, up} - {3'h0, dn};
  endfunction : cntNext

  assign ssp = (mCfg.fmtSel == 2'h1) && mCfg.sspEn; // [R14]
  assign flen = (mCfg.frameLen < LEN_MIN) ? LEN_MIN : mCfg.frameLen;
  assign dlyEff = (mDly > DLY_MAX) ? 8'h00 : mDly; // [R22]
  assign mMid = mDiv == ({1'b0, mCfg.baud[15:1]} - 16'h0001); // [R14]
  assign mEnd = mDiv == (mCfg.baud - 16'h0001);
  assign txHead = txMem[txRd] << (4'hF - flen); // [R15]
  assign rxWord = rxSh & (16'hFFFF >> (4'hF - flen));
  assign txIn = txPush && mstEnable && (txCnt != FIFO_FULL); // [R21]
  assign rxOut = rxPop && (rxCnt != 4'h0); // [R21]
  assign mStart = (mState == M_IDLE) && mstEnable && (txCnt != 4'h0);
  assign mDone = (mState == M_END) && !mArm;
  assign mMore = (mCfg.mode == TM_RX) ? (mFrames != 16'h0000)
                                      : (txCnt != 4'h0); // [R16] [R17]
  assign mTxPop = mStart || (mDone && mMore && mCfg.mode != TM_RX);
  assign mRxPush = mDone && (mCfg.mode != TM_TX)
                 && (rxCnt != FIFO_FULL); // [R16]
  assign mSelOn = ssp ? (mState == M_SYNC) : mSelAct; // [R18]

  // locked registers only take writes while the master is off
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      mCfg <= MST_CFG_RST;
      mDly <= 8'h00;
    end
    else if (clkEn && !mstEnable)
    begin
      if (mstCfgWr)
        mCfg <= mstCfgIn; // [R25]
      if (dlyWr)
        mDly <= dlyIn; // [R22]
    end

  // FIFO storage has no reset; pointers flush whenever disabled
  always_ff @(posedge mclk)
    if (clkEn)
    begin
      if (txIn)
        txMem[txWr] <= txData;
      if (mRxPush)
        rxMem[rxWr] <= rxWord;
    end

  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      txWr  <= 3'h0;
      txRd  <= 3'h0;
      txCnt <= 4'h0;
      rxWr  <= 3'h0;
      rxRd  <= 3'h0;
      rxCnt <= 4'h0;
    end
    else if (clkEn)
    begin
      if (!mstEnable)
      begin
        txWr  <= 3'h0;
        txRd  <= 3'h0;
        txCnt <= 4'h0;
        rxWr  <= 3'h0;
        rxRd  <= 3'h0;
        rxCnt <= 4'h0;
      end
      else
      begin
        txWr  <= txWr + {2'h0, txIn};
        txRd  <= txRd + {2'h0, mTxPop};
        txCnt <= cntNext(txCnt, txIn, mTxPop);
        rxWr  <= rxWr + {2'h0, mRxPush};
        rxRd  <= rxRd + {2'h0, rxOut};
        rxCnt <= cntNext(rxCnt, mRxPush, rxOut);
      end
    end

  // frame engine, MSB first, serial clock idles low
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      mState  <= M_IDLE;
      mDiv    <= 16'h0000;
      mSh     <= 16'h0000;
      mBits   <= 4'h0;
      mFrames <= 16'h0000;
      sclkM   <= 1'b0;
      mSelAct <= 1'b0;
    end
    else if (clkEn)
    begin
      mDiv <= mEnd ? 16'h0000 : mDiv + 16'h0001;
      if (!mstEnable)
      begin
        mState  <= M_IDLE;
        sclkM   <= 1'b0;
        mSelAct <= 1'b0;
      end
      else
        unique case (mState)
          M_IDLE:
            if (mStart)
            begin
              mSelAct <= 1'b1; // [R18] [R20]
              mDiv    <= 16'h0000;
              mFrames <= mCfg.rxCount; // [R17]
              mSh     <= txHead;
              mBits   <= flen;
              mState  <= ssp ? M_SYNC : M_BIT;
            end
          M_SYNC:
            if (mEnd)
              mState <= M_BIT;
          M_BIT:
            if (mMid)
              sclkM <= 1'b1;
            else if (mEnd)
            begin
              sclkM <= 1'b0;
              mSh   <= {mSh[14:0], 1'b0};
              if (mBits == 4'h0)
                mState <= M_END;
              else
                mBits <= mBits - 4'h1;
            end
          M_END:
            if (!mArm)
            begin
              if (mMore)
              begin
                if (mCfg.mode == TM_RX)
                  mFrames <= mFrames - 16'h0001;
                else
                  mSh <= txHead;
                mBits  <= flen;
                mDiv   <= 16'h0000;
                mState <= ssp ? M_SYNC : M_BIT;
              end
              else
              begin
                mState  <= M_IDLE; // [R18] [R16]
                mSelAct <= 1'b0;
              end
            end
        endcase
    end

  // sample point trails the rising edge by the programmed delay;
  // the delay must stay under half a bit or frames stretch
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      mArm    <= 1'b0;
      mDlyCnt <= 8'h00;
      rxSh    <= 16'h0000;
    end
    else if (clkEn)
    begin
      if (!mstEnable)
        mArm <= 1'b0;
      else if (mState == M_BIT && mMid)
      begin
        mArm    <= 1'b1;
        mDlyCnt <= dlyEff; // [R22]
      end
      else if (mArm && mDlyCnt == 8'h00)
      begin
        rxSh <= {rxSh[14:0], din2};
        mArm <= 1'b0;
      end
      else if (mArm)
        mDlyCnt <= mDlyCnt - 8'h01;
    end

  // ----------------------------------------------------------------
  // status and pin mux
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      rxData     <= 16'h0000;
      txEmpty    <= 1'b1;
      txNotFull  <= 1'b1;
      rxFull     <= 1'b0;
      rxNotEmpty <= 1'b0;
      mstBusy    <= 1'b0;
    end
    else if (clkEn)
    begin
      rxData     <= rxMem[rxRd]; // [R21]
      txEmpty    <= txCnt == 4'h0;
      txNotFull  <= txCnt != FIFO_FULL;
      rxFull     <= rxCnt == FIFO_FULL;
      rxNotEmpty <= rxCnt != 4'h0;
      mstBusy    <= mState != M_IDLE;
    end

  // registered mux keeps pins glitch free across owner changes
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      sclkOut <= 1'b0;
      sclkOe  <= 1'b0;
      sdoOut  <= 1'b0;
      sdoOe   <= 1'b0;
      selN    <= 5'h1F;
      selOe   <= 5'h00;
      manualDataInLevel <= 1'b0;
    end
    else if (clkEn)
    begin
      manualDataInLevel <= din2; // [R5]
      if (ifOwner == OWN_MST)
      begin
        sclkOut <= sclkM; // [R24]
        sclkOe  <= 1'b1;
        sdoOut  <= mSh[15];
        sdoOe   <= 1'b1;
        selN    <= mSelOn ? ~mCfg.selMask : 5'h1F; // [R20]
        selOe   <= 5'h1F;
      end
      else if (manualCtl.en)
      begin
        sclkOut <= manualCtl.clk; // [R5]
        sclkOe  <= manualCtl.clkOe;
        sdoOut  <= manualCtl.dOut;
        sdoOe   <= manualCtl.doOe;
        selN    <= {1'b1, manualCtl.csLvl};
        selOe   <= {1'b0, manualCtl.csOe};
      end
      else
      begin
        sclkOut <= sclkB; // [R24]
        sclkOe  <= 1'b1;
        sdoOut  <= bSh[47];
        sdoOe   <= 1'b1;
        selN    <= {1'b1, bSelN};
        selOe   <= 5'h0F;
      end
    end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_cs_onehot: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
    $countones(~bSelN) <= 1) else $error("boot selects not one-hot");
  a_boot_cs_sel: assert property (@(posedge mclk) // [R3]
    disable iff (!reset_n) $rose(bCsAct) |->
    bCs == ($past(bCfg.wide) ? 2'h0 : $past(bootAddr[25:24])))
    else $error("boot select does not match window");
  a_cmd_choice: assert property (@(posedge mclk) // [R8]
    disable iff (!reset_n) $rose(bCsAct) |->
    bSh[47:40] == ($past(bCfg.quick) ? CMD_QUICK : CMD_READ))
    else $error("wrong read command");
  a_addr_len: assert property (@(posedge mclk) // [R2]
    disable iff (!reset_n) $rose(bCsAct) && !bCfg.quick |->
    bLeft == (bCfg.wide ? 6'h28 : 6'h20))
    else $error("wrong header length");
  a_sample_edge: assert property (@(posedge mclk) // [R12]
    disable iff (!reset_n) clkEn && bState == B_DATA && bEnd |-> sclkB)
    else $error("data sampled off the high phase");
  a_mux_owner: assert property (@(posedge mclk) // [R24]
    disable iff (!reset_n) clkEn && ifOwner == OWN_MST |=>
    sdoOut == $past(mSh[15]) && sclkOut == $past(sclkM))
    else $error("pins not following the master");
  a_manual_pins: assert property (@(posedge mclk) // [R5]
    disable iff (!reset_n)
    clkEn && ifOwner != OWN_MST && manualCtl.en |=>
    sclkOe == $past(manualCtl.clkOe) && selN[3:0] == $past(manualCtl.csLvl))
    else $error("manual pin control ignored");
  a_cfg_locked: assert property (@(posedge mclk) // [R25]
    disable iff (!reset_n) mstEnable |=> mCfg == $past(mCfg))
    else $error("config changed while enabled");
  a_dly_locked: assert property (@(posedge mclk) // [R22]
    disable iff (!reset_n) mstEnable |=> mDly == $past(mDly))
    else $error("sample delay changed while enabled");
  a_fifo_flags: assert property (@(posedge mclk) // [R21]
    disable iff (!reset_n) clkEn |=>
    txEmpty == ($past(txCnt) == 4'h0) && rxFull == ($past(rxCnt) == 4'h8))
    else $error("FIFO flag wrong");
endmodule : sfb_serial_top

// ---- verification/sfb_flash_model.sv ----
// sfb_flash_model: behavioural serial flash that answers read commands
// assumes mode 0 clocking; each byte read back equals the low byte of its address
`timescale 1ns/1ps
module sfb_flash_model
(
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        mosi,
  input  wire logic        wide,
  output logic             miso,
  output logic [7:0]       cmd,
  output logic [31:0]      adr
);
  logic [47:0] hdr;
  int          n;
  int          k;
  logic [7:0]  b;
  initial miso = 1'b0;
  // header bits are counted from the start of each selection
  always @(negedge csN) n = 0;
  always @(posedge sclk)
  begin
    if (!csN)
    begin
      hdr = {hdr[46:0], mosi};
      n++;
      if (n == 8) cmd = hdr[7:0];
      if (n == (wide ? 40 : 32)) adr = wide ? hdr[31:0] : {8'h00, hdr[23:0]};
    end
  end
  // stream runs on while selected, so prefetch sees sequential bytes
  always @(negedge sclk)
  begin
    if (!csN && n >= 32 + (wide ? 8 : 0) + (cmd == 8'h0B ? 8 : 0))
    begin
      k = n - 32 - (wide ? 8 : 0) - (cmd == 8'h0B ? 8 : 0);
      b = adr[7:0] + 8'(k / 8);
      miso = b[7 - (k % 8)];
    end
  end
  // released line shows the inverse so a stale bit is never trusted
  always @(posedge csN) miso = ~miso;
endmodule : sfb_flash_model

// ---- verification/sfb_serial_top_tb.sv ----
// sfb_serial_top_tb: boot reader and fifo master scenarios
// assumes the flash model on select 0..3 and sdo looped to sdi for master
`timescale 1ns/1ps
module sfb_serial_top_tb
  import sfb_pkg::*;
;
  logic mclk, reset_n, clkEn, bootCfgWr, bootReq, mstEnable, mstCfgWr;
  logic dlyWr, txPush, rxPop, serialDataIn, bootAck, txEmpty, txNotFull;
  logic rxFull, rxNotEmpty, mstBusy, manualDataInLevel, sclkOut, sclkOe;
  logic sdoOut, sdoOe, miso, wide;
  logic [1:0]    ifOwner;
  logic [27:0]   bootAddr;
  logic [31:0]   bootData, adr, d;
  logic [15:0]   txData, rxData;
  logic [7:0]    dlyIn, cmd;
  logic [4:0]    selN, selOe, s;
  sfb_boot_cfg_s bootCfgIn;
  sfb_manual_s   manualCtl;
  sfb_mst_cfg_s  mstCfgIn;
  int            n_mismatch, n_checks, cyc, c;
  // master pins loop back; manual mode reads its own data out bit
  assign serialDataIn = ifOwner == OWN_MST ? sdoOut :
                        manualCtl.en ? manualCtl.dOut : miso;
  sfb_serial_top uut (.*);
  sfb_flash_model flash (.sclk(sclkOut), .csN(&selN[3:0]), .mosi(sdoOut),
    .wide(wide), .miso(miso), .cmd(cmd), .adr(adr));
  always #4 mclk = ~mclk;
  // hang guard: the whole run needs well under this many cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [31:0] pat(input logic [7:0] a);
    return {a, a + 8'h01, a + 8'h02, a + 8'h03};
  endfunction : pat
  // request held until ack; data and active selects taken at the ack
  task automatic boot_read(input logic [27:0] a);
    @(negedge mclk);
    bootReq = 1'b1;
    bootAddr = a;
    c = 0;
    do
    begin
      @(posedge mclk);
      #1;
      c++;
    end
    while (bootAck !== 1'b1 && c < 5000);
    d = bootData;
    s = ~selN;
    @(negedge mclk);
    bootReq = 1'b0;
  endtask : boot_read
  task automatic boot_cfg(input sfb_boot_cfg_s v);
    @(negedge mclk);
    bootCfgIn = v;
    bootCfgWr = 1'b1;
    @(negedge mclk);
    bootCfgWr = 1'b0;
  endtask : boot_cfg
  task automatic t_boot;
    boot_read(28'h200_0040);
    chk("bootData", pat(8'h40), d);
    chk("bootSel", 32'h0000_0004, 32'(s));
    chk("flashAdr", 32'h0000_0040, adr);
    chk("flashCmd", 32'h0000_0003, 32'(cmd));
    // let the speculative fetch of the next word finish first
    repeat (600) @(negedge mclk);
    boot_read(28'h200_0044);
    chk("hitData", pat(8'h44), d);
    chk("hitFast", 32'h0000_0001, 32'(c <= 3));
    boot_cfg('{8'h05, 4'h1, 1'b1, 1'b0});
    boot_read(28'h100_0120);
    chk("quickCmd", 32'h0000_000B, 32'(cmd));
    chk("quickData", pat(8'h20), d);
    chk("quickSel", 32'h0000_0002, 32'(s));
    wide = 1'b1;
    boot_cfg('{8'h05, 4'h1, 1'b0, 1'b1});
    boot_read(28'h300_0080);
    chk("wideSel", 32'h0000_0001, 32'(s));
    chk("wideAdr", 32'h0300_0080, adr);
    chk("wideData", pat(8'h80), d);
  endtask : t_boot
  task automatic t_manual;
    @(negedge mclk);
    manualCtl = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, 4'b1110};
    repeat (4) @(negedge mclk);
    chk("manClk", 32'h0000_0001, 32'(sclkOut));
    chk("manClkOe", 32'h0000_0000, 32'(sclkOe));
    chk("manSel", 32'h0000_000E, 32'(selN[3:0]));
    chk("manSelOe", 32'h0000_000F, 32'(selOe));
    chk("manSdi", 32'h0000_0001, 32'(manualDataInLevel));
    manualCtl = '0;
  endtask : t_manual
  task automatic mst_cfg(input logic [3:0] f, input sfb_tmode_e m,
                         input logic [15:0] r, input logic p);
    @(negedge mclk);
    mstEnable = 1'b0;
    mstCfgIn = '{f, m, {1'b0, p}, p, 16'h0008, r, 5'h02};
    mstCfgWr = 1'b1;
    dlyIn = 8'h02;
    dlyWr = 1'b1;
    @(negedge mclk);
    mstCfgWr = 1'b0;
    dlyWr = 1'b0;
    mstEnable = 1'b1;
  endtask : mst_cfg
  task automatic push(input logic [15:0] v);
    @(negedge mclk);
    txPush = 1'b1;
    txData = v;
    @(negedge mclk);
    txPush = 1'b0;
  endtask : push
  task automatic pop;
    @(negedge mclk);
    rxPop = 1'b1;
    @(negedge mclk);
    rxPop = 1'b0;
    repeat (2) @(negedge mclk);
  endtask : pop
  // busy rises late, so empty and not busy are both awaited
  task automatic wait_idle;
    repeat (4) @(negedge mclk);
    c = 0;
    while (!(txEmpty === 1'b1 && mstBusy === 1'b0) && c < 3000)
    begin
      @(negedge mclk);
      c++;
    end
  endtask : wait_idle
  task automatic t_master;
    @(negedge mclk);
    ifOwner = OWN_MST;
    repeat (3) @(negedge mclk);
    chk("ownIdle", 32'h0000_001F, 32'(selN));
    chk("ownOe", 32'h0000_001F, 32'(selOe));
    mst_cfg(4'h3, TM_TXRX, 16'h0000, 1'b0);
    push(16'h00A5);
    push(16'h003C);
    chk("xferSel", 32'h0000_001D, 32'(selN));
    wait_idle();
    chk("endSel", 32'h0000_001F, 32'(selN));
    chk("rx0", 32'h0000_0005, 32'(rxData));
    pop();
    chk("rx1", 32'h0000_000C, 32'(rxData));
    pop();
    chk("rxDrained", 32'h0000_0000, 32'(rxNotEmpty));
    // sync framing: select low for one bit period ahead of the frame
    mst_cfg(4'h3, TM_TXRX, 16'h0000, 1'b1);
    push(16'h000A);
    repeat (2) @(negedge mclk);
    chk("sspSel", 32'h0000_001D, 32'(selN));
    repeat (10) @(negedge mclk);
    chk("sspSelOff", 32'h0000_001F, 32'(selN));
    wait_idle();
    chk("sspRx", 32'h0000_000A, 32'(rxData));
    mst_cfg(4'h7, TM_TX, 16'h0000, 1'b0);
    repeat (9) push(16'h0055);
    @(negedge mclk);
    chk("txNotFull", 32'h0000_0000, 32'(txNotFull));
    wait_idle();
    chk("txOnlyRx", 32'h0000_0000, 32'(rxNotEmpty));
    mst_cfg(4'h7, TM_RX, 16'h0007, 1'b0);
    @(negedge mclk);
    mstCfgIn.mode = TM_TX;
    mstCfgIn.rxCount = 16'h0000;
    mstCfgWr = 1'b1;
    @(negedge mclk);
    mstCfgWr = 1'b0;
    push(16'h0000);
    wait_idle();
    chk("rxFull", 32'h0000_0001, 32'(rxFull));
    c = 0;
    while (rxNotEmpty === 1'b1 && c < 9)
    begin
      pop();
      c++;
    end
    chk("rxFrames", 32'h0000_0008, 32'(c));
  endtask : t_master
  task automatic print_verdict;
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  initial
  begin
    {mclk, reset_n, bootCfgWr, bootReq, mstEnable, mstCfgWr, dlyWr} = '0;
    {txPush, rxPop, wide, ifOwner, bootAddr, txData, dlyIn} = '0;
    clkEn = 1'b1;
    bootCfgIn = BOOT_CFG_RST;
    manualCtl = '0;
    mstCfgIn = MST_CFG_RST;
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    t_boot();
    t_manual();
    t_master();
    print_verdict();
  end
endmodule : sfb_serial_top_tb
